//--- logic/emsr_consts.vh
// Notes on behaviour
// - unaligned access detail: store flag in bit 21, register number in 22:26.
// - bus error detail: bit 20 marks local memory bus error, rest zero.
// - divide detail: bit 20 is 0 for divide by zero, 1 for overflow.
// - stream detail: link index in 23:26, bits 20:22 zero.
// - data storage detail: bit 20 zone fault, bit 21 store.
// - instruction storage zone in 20; data miss store in 21; instr miss zero.
// - capture delay-slot branch target while handler inactive.
// - branch target read-only at 0x000b, only with exceptions, resets zero.
// - float flags sticky; instructions set, only a special write clears.
// - float flags at 0x0007, bits 27..31, reset zero.
// - stream fault data captured, read at 0x000d when configured.
// - base r1 address below floor limit signals overflow; exception only when enabled.
// - base r1 address above ceiling signals underflow; ceiling resets all ones.
// - process tag 8 bits at 0x1000; stored to entry tag on high write.
// - high read outside user mode copies entry tag into process tag.
// - user mode zones: 00 deny, 01/10 entry bits, 11 force write/exec.
// - privileged zones: 00/01 entry bits, 10/11 force write/exec.
// - zone register has sixteen 2-bit fields, only configured ones kept.
// - translation low at 0x1003 accesses entry picked by index register.
// - table entries cleared only at configuration load, not by resets.
// - physical address from page number field, only bits page size needs.
// - fetch permit bit 22; fetching a clear page in an unforced zone raises storage fault.
// - detail field bits 20:26 of cause register at 0x0005 with cause code.
// - handler active bit gates branch target capture.
`ifndef EMSR_CONSTS_VH
`define EMSR_CONSTS_VH
// selectors
`define SEL_CAUSE 16'h0005
`define SEL_FLOAT 16'h0007
`define SEL_BRANCH 16'h000b
`define SEL_STREAM 16'h000d
`define SEL_FLOOR 16'h0800
`define SEL_CEIL 16'h0802
`define SEL_PTAG 16'h1000
`define SEL_ZONE 16'h1001
`define SEL_XLO 16'h1003
// reset values
`define RST_ZERO 32'h0000_0000
`define RST_CEIL 32'hffff_ffff
// cause codes
`define EC_STREAM 5'h00
`define EC_UNALIGN 5'h01
`define EC_IBUS 5'h03
`define EC_DBUS 5'h04
`define EC_DIV 5'h05
`define EC_DSTORE 5'h10
`define EC_ISTORE 5'h11
`define EC_DMISS 5'h12
`define EC_IMISS 5'h13
// cause register fields (vector bit = 31 - msb-first bit)
`define CR_SLOT 12
`define DT_HI 11
`define DT_LO 5
`define DT_W 7
// float flag field, msb-first bits 27..31
`define FF_HI 4
`define FF_W 5
// process tag field, msb-first bits 24:31
`define PT_W 8
// table low word fields
`define XL_PAGE_HI 31
`define XL_PAGE_LO 10
`define XL_FETCH 9
`define XL_WR 8
`define XL_ZS_HI 7
`define XL_ZS_LO 4
// table geometry
`define XL_IDX_W 6
`define XL_DEPTH 64
// page offset width = base + step * size code
`define PG_OFS_BASE 10
`define PG_OFS_STEP 2
// zone field codes
`define ZN_DENY 2'h0
`define ZN_PLAIN 2'h1
`define ZN_FORCE 2'h3
`endif

//--- logic/emsr_special_regs.v
`include "emsr_consts.vh"
`default_nettype none
module emsr_special_regs #(
    parameter EXC_CFG = 1,
    parameter STACK_PROT_CFG = 1,
    parameter mmu_level_param = 3,
    parameter area_saving_param = 0,
    parameter zone_count_param = 16,
    parameter stream_link_count_param = 4,
    parameter stream_fault_enable_param = 1
) (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    input wire config_load_in,
    // special register moves
    input wire [15:0] special_reg_selector_in,
    input wire rd_en_in,
    input wire wr_en_in,
    input wire [31:0] wdata_in,
    output reg [31:0] rdata_out,
    // processor state
    input wire handler_active_bit_in,
    input wire user_mode_bit_in,
    input wire exc_enable_in,
    // exception report
    input wire exc_valid_in,
    input wire [4:0] exc_cause_in,
    input wire delay_slot_flag_in,
    input wire exc_store_in,
    input wire [4:0] exc_reg_in,
    input wire exc_lmb_err_in,
    input wire div_fault_kind_in,
    input wire [3:0] exc_link_in,
    input wire zone_fault_flag_in,
    input wire [31:0] stream_data_in,
    // delay-slot branch
    input wire dslot_branch_in,
    input wire [31:0] branch_target_in,
    // float flag events
    input wire fp_set_in,
    input wire [4:0] fp_flags_in,
    // stack check
    input wire ls_valid_in,
    input wire ls_base_r1_in,
    input wire [31:0] ls_addr_in,
    output reg stack_overflow_out,
    output reg stack_underflow_out,
    output reg stack_fault_out,
    // translation high side and index
    input wire [5:0] xlate_index_reg_in,
    input wire xhi_wr_in,
    input wire xhi_rd_in,
    output reg [7:0] entry_owner_tag_out,
    // translation lookup
    input wire lk_req_in,
    input wire [5:0] lk_index_in,
    input wire [2:0] lk_size_in,
    input wire lk_entry_valid_in,
    input wire [31:0] lk_vaddr_in,
    output reg lk_ack_out,
    output reg [31:0] lk_paddr_out,
    output reg lk_access_ok_out,
    output reg lk_write_ok_out,
    output reg lk_fetch_ok_out,
    output reg lk_fetch_fault_out
);

    localparam MMU_ON = (mmu_level_param > 1) && (area_saving_param == 0);
    localparam ZONE_ON = MMU_ON && (zone_count_param > 0);
    localparam STREAM_ON = (stream_link_count_param > 0) &&
                           (stream_fault_enable_param == 1);

    // register state
    reg [31:0] cause_q;
    reg [31:0] branch_q;
    reg [`FF_W-1:0] float_q;
    reg [31:0] stream_q;
    reg [31:0] floor_q;
    reg [31:0] ceil_q;
    reg [`PT_W-1:0] ptag_q;
    reg [31:0] zone_q;
    reg [31:0] xlate_mem [0:`XL_DEPTH-1];
    reg [`PT_W-1:0] tag_mem [0:`XL_DEPTH-1];
    wire [31:0] zone_mask;
    integer i;

    // implemented zone bits: fields 0.. at the top of the word
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_zmask
            assign zone_mask[31-2*g -: 2] =
                (ZONE_ON && g < zone_count_param) ? 2'h3 : 2'h0;
        end
    endgenerate

    // selector decode for the write strobes; the read mux decodes in its own case
    function sel_is;
        input [15:0] s;
        input [15:0] code;
        begin
            sel_is = (s == code);
        end
    endfunction

    // zone field of a given zone number, msb-first layout
    function [1:0] zone_field;
        input [31:0] z;
        input [3:0] n;
        begin
            zone_field = z[31 - {n, 1'b0} -: 2];
        end
    endfunction

    // detail field built per cause; unknown causes leave it zero
    reg [`DT_W-1:0] detail;
    always @* begin
        detail = {`DT_W{1'b0}};
        case (exc_cause_in)
            `EC_UNALIGN: detail = {1'b0, exc_store_in, exc_reg_in};
            `EC_IBUS, `EC_DBUS: detail = {exc_lmb_err_in, 6'h00};
            `EC_DIV: detail = {div_fault_kind_in, 6'h00};
            `EC_STREAM: detail = {3'h0, exc_link_in};
            `EC_DSTORE:
                detail = {zone_fault_flag_in, exc_store_in, 5'h00};
            `EC_ISTORE: detail = {zone_fault_flag_in, 6'h00};
            `EC_DMISS: detail = {1'b0, exc_store_in, 5'h00};
            `EC_IMISS: detail = {`DT_W{1'b0}};
            default: detail = {`DT_W{1'b0}};
        endcase
    end

    wire wr_float = wr_en_in && sel_is(special_reg_selector_in, `SEL_FLOAT);
    wire wr_floor = wr_en_in && sel_is(special_reg_selector_in, `SEL_FLOOR);
    wire wr_ceil = wr_en_in && sel_is(special_reg_selector_in, `SEL_CEIL);
    wire wr_ptag = wr_en_in && sel_is(special_reg_selector_in, `SEL_PTAG);
    wire wr_zone = wr_en_in && sel_is(special_reg_selector_in, `SEL_ZONE);
    wire wr_xlo = wr_en_in && sel_is(special_reg_selector_in, `SEL_XLO);
    wire stream_cap = exc_valid_in && (exc_cause_in == `EC_STREAM);

    // exception cause register: detail and code latched on each report
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cause_q <= `RST_ZERO;
        end else if (exc_valid_in) begin
            cause_q <= `RST_ZERO;
            cause_q[`CR_SLOT] <= delay_slot_flag_in;
            cause_q[`DT_HI:`DT_LO] <= detail;
            cause_q[4:0] <= exc_cause_in;
        end
    end

    // branch target follows delay-slot branches outside a handler
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            branch_q <= `RST_ZERO;
        end else if (EXC_CFG != 0 && dslot_branch_in &&
                     !handler_active_bit_in) begin
            branch_q <= branch_target_in;
        end
    end

    // sticky float flags; a set in the clearing cycle still lands
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            float_q <= {`FF_W{1'b0}};
        end else begin
            float_q <= (wr_float ? wdata_in[`FF_HI:0] : float_q) |
                       (fp_set_in ? fp_flags_in : {`FF_W{1'b0}});
        end
    end

    // stream fault data captured with the stream exception
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stream_q <= `RST_ZERO;
        end else if (STREAM_ON && stream_cap) begin
            stream_q <= stream_data_in;
        end
    end

    // stack limits, writable only when protection is configured
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            floor_q <= `RST_ZERO;
            ceil_q <= `RST_CEIL;
        end else if (STACK_PROT_CFG != 0) begin
            if (wr_floor) begin
                floor_q <= wdata_in;
            end
            if (wr_ceil) begin
                ceil_q <= wdata_in;
            end
        end
    end

    // stack check result, one cycle after the access is seen
    wire under_floor = ls_addr_in < floor_q;
    wire over_ceil = ls_addr_in > ceil_q;
    wire stk_chk = (STACK_PROT_CFG != 0) && ls_valid_in && ls_base_r1_in;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stack_overflow_out <= 1'b0;
            stack_underflow_out <= 1'b0;
            stack_fault_out <= 1'b0;
        end else begin
            stack_overflow_out <= stk_chk && under_floor;
            stack_underflow_out <= stk_chk && over_ceil;
            // exception only when software enabled them
            stack_fault_out <= stk_chk && (under_floor || over_ceil) &&
                               exc_enable_in;
        end
    end

    // process tag and zone override
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ptag_q <= {`PT_W{1'b0}};
            zone_q <= `RST_ZERO;
        end else begin
            if (MMU_ON && xhi_rd_in && !user_mode_bit_in) begin
                ptag_q <= tag_mem[xlate_index_reg_in];
            end else if (MMU_ON && wr_ptag) begin
                ptag_q <= wdata_in[`PT_W-1:0];
            end
            if (wr_zone) begin
                zone_q <= wdata_in & zone_mask;
            end
        end
    end

    // translation table: no reset path, cleared only at config load
    always @(posedge clk_in) begin
        if (config_load_in) begin
            for (i = 0; i < `XL_DEPTH; i = i + 1) begin
                xlate_mem[i] <= `RST_ZERO;
                tag_mem[i] <= {`PT_W{1'b0}};
            end
        end else if (MMU_ON) begin
            if (wr_xlo) begin
                xlate_mem[xlate_index_reg_in] <= wdata_in;
            end
            if (xhi_wr_in) begin
                tag_mem[xlate_index_reg_in] <= ptag_q;
            end
        end
    end

    // read mux; absent registers and reserved bits read zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = `RST_ZERO;
        case (special_reg_selector_in)
            `SEL_CAUSE: rd_mux = cause_q;
            `SEL_FLOAT: rd_mux = {27'h0, float_q};
            `SEL_BRANCH:
                rd_mux = (EXC_CFG != 0) ? branch_q : `RST_ZERO;
            `SEL_STREAM:
                rd_mux = STREAM_ON ? stream_q : `RST_ZERO;
            `SEL_FLOOR:
                rd_mux = (STACK_PROT_CFG != 0) ? floor_q : `RST_ZERO;
            `SEL_CEIL:
                rd_mux = (STACK_PROT_CFG != 0) ? ceil_q : `RST_ZERO;
            `SEL_PTAG:
                rd_mux = MMU_ON ? {24'h0, ptag_q} : `RST_ZERO;
            `SEL_ZONE: rd_mux = zone_q;
            `SEL_XLO:
                rd_mux = MMU_ON ? xlate_mem[xlate_index_reg_in] :
                         `RST_ZERO;
            default: rd_mux = `RST_ZERO;
        endcase
    end

    // read data and owner tag are registered
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= `RST_ZERO;
            entry_owner_tag_out <= {`PT_W{1'b0}};
        end else begin
            if (rd_en_in) begin
                rdata_out <= rd_mux;
            end
            entry_owner_tag_out <= tag_mem[xlate_index_reg_in];
        end
    end

    // lookup: entry word, zone decision and page masking
    wire [31:0] lk_word = xlate_mem[lk_index_in];
    wire [1:0] lk_zone = ZONE_ON ?
        zone_field(zone_q, lk_word[`XL_ZS_HI:`XL_ZS_LO]) : `ZN_PLAIN;
    reg lk_deny;
    reg lk_force;
    always @* begin
        if (user_mode_bit_in) begin
            lk_deny = (lk_zone == `ZN_DENY);
            lk_force = (lk_zone == `ZN_FORCE);
        end else begin
            lk_deny = 1'b0;
            lk_force = lk_zone[1];
        end
    end

    // offset bits kept from the virtual address, the rest from the page
    wire [31:0] ofs_sum = `PG_OFS_BASE + `PG_OFS_STEP * lk_size_in;
    wire [31:0] ofs_mask = ~(32'hffff_ffff << ofs_sum[4:0]);
    wire [31:0] page_addr = {lk_word[`XL_PAGE_HI:`XL_PAGE_LO], 10'h000};
    wire lk_ok = lk_entry_valid_in && !lk_deny;
    wire lk_fetch = lk_ok && (lk_word[`XL_FETCH] || lk_force);

    // lookup answers one cycle after the request
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lk_ack_out <= 1'b0;
            lk_paddr_out <= `RST_ZERO;
            lk_access_ok_out <= 1'b0;
            lk_write_ok_out <= 1'b0;
            lk_fetch_ok_out <= 1'b0;
            lk_fetch_fault_out <= 1'b0;
        end else begin
            lk_ack_out <= lk_req_in && MMU_ON;
            if (lk_req_in && MMU_ON) begin
                // page bits under the offset are masked off here, not left to software
                lk_paddr_out <= (page_addr & ~ofs_mask) |
                                (lk_vaddr_in & ofs_mask);
                lk_access_ok_out <= lk_ok;
                lk_write_ok_out <= lk_ok && (lk_word[`XL_WR] || lk_force);
                lk_fetch_ok_out <= lk_fetch;
                lk_fetch_fault_out <= lk_ok && !lk_fetch;
            end
        end
    end

endmodule // emsr_special_regs
`default_nettype wire

//--- tb/emsr_special_regs_assertions.sv
`default_nettype none
module emsr_special_regs_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // special register moves
    input wire logic [15:0] special_reg_selector_in,
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire logic [31:0] wdata_in,
    input wire logic [31:0] rdata_out,
    // stack check
    input wire logic exc_enable_in,
    input wire logic ls_valid_in,
    input wire logic ls_base_r1_in,
    input wire logic [31:0] ls_addr_in,
    input wire logic stack_overflow_out,
    input wire logic stack_underflow_out,
    input wire logic stack_fault_out,
    // lookup
    input wire logic lk_req_in,
    input wire logic lk_ack_out,
    input wire logic lk_fetch_ok_out,
    input wire logic lk_fetch_fault_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] floor_q;
    logic [31:0] ceil_q;
    wire [15:0] s = special_reg_selector_in;
    wire rq = ls_valid_in && ls_base_r1_in;
    wire lo = rq && (ls_addr_in < floor_q);
    wire hi = rq && (ls_addr_in > ceil_q);
    // shadow limits: the checker cannot see inside the block
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            floor_q <= 32'h0000_0000;
            ceil_q <= 32'hffff_ffff;
        end else if (wr_en_in && s == 16'h0800) begin
            floor_q <= wdata_in;
        end else if (wr_en_in && s == 16'h0802) begin
            ceil_q <= wdata_in;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // stack limits, pulses one cycle after the access
    stack_low_a: assert property (lo |=> stack_overflow_out)
        else $error("overflow not flagged");
    stack_high_a: assert property (hi |=> stack_underflow_out)
        else $error("underflow not flagged");
    stack_quiet_a: assert property (!lo && !hi |=>
        !stack_overflow_out && !stack_underflow_out)
        else $error("stack pulse without cause");
    stack_fault_a: assert property (lo || hi |=>
        stack_fault_out == $past(exc_enable_in))
        else $error("stack fault not gated by enable");
    // register reads
    limit_read_a: assert property (rd_en_in && s == 16'h0800
        |=> rdata_out == $past(floor_q))
        else $error("floor readback wrong");
    float_rsvd_a: assert property (rd_en_in && s == 16'h0007
        |=> rdata_out[31:5] == 27'h0)
        else $error("float reserved bits set");
    tag_rsvd_a: assert property (rd_en_in && s == 16'h1000
        |=> rdata_out[31:8] == 24'h0)
        else $error("tag reserved bits set");
    unmapped_zero_a: assert property (rd_en_in && s == 16'h0003
        |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    // lookup
    look_ack_a: assert property (lk_req_in |=> lk_ack_out)
        else $error("lookup not answered");
    fetch_ok_a: assert property (lk_ack_out && lk_fetch_ok_out
        |-> !lk_fetch_fault_out)
        else $error("fetch fault on permitted page");
    cov_low: cover property (lo);
    cov_high: cover property (hi);
    cov_fault: cover property (lk_ack_out && lk_fetch_fault_out);
endmodule // emsr_special_regs_chk
`default_nettype wire

//--- tb/emsr_core_model.sv
`default_nettype none
module emsr_core_model (
    // clock
    input wire logic clk_in,
    // special register moves
    output logic [15:0] sel_out,
    output logic rd_out,
    output logic wr_out,
    output logic [31:0] wdata_out,
    input wire logic [31:0] rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle lines at start
    initial begin
        sel_out = 16'h0000;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
    end
    // move-to; released lines inverted so stale values never match
    task automatic mts(input logic [15:0] sv, input logic [31:0] dv);
        @(negedge clk_in);
        sel_out = sv;
        wdata_out = dv;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        sel_out = ~sv;
        wdata_out = ~dv;
    endtask
    // move-from; data stands from the taking edge, read at the next falling edge
    task automatic mfs(input logic [15:0] sv, output logic [31:0] dv);
        @(negedge clk_in);
        sel_out = sv;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        sel_out = ~sv;
        dv = rdata_in;
    endtask
endmodule // emsr_core_model
`default_nettype wire

//--- tb/emsr_special_regs_tb_top.sv
`include "emsr_consts.vh"
`default_nettype none
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module emsr_special_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] c, fl, rg;
        logic [3:0] lk;
        logic [6:0] det;
    } emsr_row_t;
    emsr_row_t rows[$];
    int mismatches = 0;
    int check_count = 0;
    logic clk_in, arst_n_in, config_load_in, rd_en_in, wr_en_in;
    logic handler_active_bit_in, user_mode_bit_in, exc_enable_in;
    logic exc_valid_in, delay_slot_flag_in, exc_store_in, exc_lmb_err_in;
    logic div_fault_kind_in, zone_fault_flag_in, dslot_branch_in, fp_set_in;
    logic ls_valid_in, ls_base_r1_in, xhi_wr_in, xhi_rd_in, lk_req_in;
    logic lk_entry_valid_in, stack_overflow_out, stack_underflow_out;
    logic stack_fault_out, lk_ack_out, lk_access_ok_out, lk_write_ok_out;
    logic lk_fetch_ok_out, lk_fetch_fault_out;
    logic [15:0] special_reg_selector_in;
    logic [4:0] exc_cause_in, exc_reg_in, fp_flags_in;
    logic [3:0] exc_link_in;
    logic [5:0] xlate_index_reg_in, lk_index_in;
    logic [2:0] lk_size_in;
    logic [7:0] entry_owner_tag_out;
    logic [31:0] wdata_in, rdata_out, stream_data_in, branch_target_in;
    logic [31:0] ls_addr_in, lk_vaddr_in, lk_paddr_out, e;
    logic [31:0] lo_tab[5];
    emsr_special_regs u_emsr_special_regs (.*);
    emsr_core_model u_emsr_core_model (.clk_in(clk_in),
        .sel_out(special_reg_selector_in), .rd_out(rd_en_in),
        .wr_out(wr_en_in), .wdata_out(wdata_in), .rdata_in(rdata_out));
    // 10 mhz clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // four-state compare so an unknown never passes
    task automatic chk(input string n, input logic [31:0] x, y);
        check_count++;
        if (y !== x) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, x, y);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rc(input string n, input logic [15:0] sv,
                      input logic [31:0] x);
        logic [31:0] v;
        u_emsr_core_model.mfs(sv, v);
        `CHK(n, x, v);
    endtask
    task automatic pulse(ref logic p);
        @(negedge clk_in);
        p = 1'b1;
        @(negedge clk_in);
        p = 1'b0;
    endtask
    task automatic add(input logic [4:0] c, fl, rg, input logic [3:0] lk,
                       input logic [6:0] det);
        rows.push_back(emsr_row_t'{c, fl, rg, lk, det});
    endtask
    // values every reset restores
    task automatic rst_vals;
        rc("float", `SEL_FLOAT, 32'h0);
        rc("branch", `SEL_BRANCH, 32'h0);
        rc("sdata", `SEL_STREAM, 32'h0);
        rc("floor", `SEL_FLOOR, 32'h0);
        rc("ceil", `SEL_CEIL, 32'hffff_ffff);
        rc("ptag", `SEL_PTAG, 32'h0);
        rc("zone", `SEL_ZONE, 32'h0);
        rc("cause", `SEL_CAUSE, 32'h0);
        rc("unmapped", 16'h0003, 32'h0);
    endtask
    task automatic ls(input logic [31:0] a, input logic b, en,
                      input logic [2:0] e3);
        logic [2:0] s3;
        ls_addr_in = a;
        ls_base_r1_in = b;
        exc_enable_in = en;
        pulse(ls_valid_in);
        s3 = {stack_overflow_out, stack_underflow_out, stack_fault_out};
        `CHK("stack", e3, s3);
    endtask
    // lookup; e4 = access, write, fetch, fetch fault
    task automatic lku(input logic u, input logic [5:0] x,
                       input logic [2:0] z, input logic [3:0] e4);
        logic [31:0] m;
        logic [3:0] p4;
        m = (32'h1 << (10 + 2 * z)) - 32'h1;
        user_mode_bit_in = u;
        lk_index_in = x;
        lk_size_in = z;
        lk_vaddr_in = 32'hfedc_ba98;
        pulse(lk_req_in);
        p4 = {lk_access_ok_out, lk_write_ok_out, lk_fetch_ok_out,
              lk_fetch_fault_out};
        `CHK("access", e4[3], p4[3]);
        if (e4[3]) begin
            `CHK("perm", e4, p4);
            m = (lo_tab[x] & ~m) | (32'hfedc_ba98 & m);
            `CHK("paddr", m, lk_paddr_out);
        end
    endtask
    // a hang still ends with a verdict
    initial begin
        #2_000_000;
        mismatches++;
        end_of_test();
    end
    initial begin
        arst_n_in = 1'b0;
        config_load_in = 1'b1;
        {handler_active_bit_in, user_mode_bit_in, exc_enable_in,
         exc_valid_in, exc_cause_in, delay_slot_flag_in, exc_store_in,
         exc_reg_in, exc_lmb_err_in, div_fault_kind_in, exc_link_in,
         zone_fault_flag_in, stream_data_in, dslot_branch_in,
         branch_target_in, fp_set_in, fp_flags_in, ls_valid_in,
         ls_base_r1_in, ls_addr_in, xlate_index_reg_in, xhi_wr_in,
         xhi_rd_in, lk_req_in, lk_index_in, lk_size_in, lk_vaddr_in} = '0;
        lk_entry_valid_in = 1'b1;
        repeat (8) @(negedge clk_in);
        arst_n_in = 1'b1;
        config_load_in = 1'b0;
        rst_vals();
        // cause, flags {slot,store,lmb,div,zone}, reg, link, detail
        add(5'h01, 5'b01111, 5'h05, 4'hf, 7'h25);
        add(5'h01, 5'b10111, 5'h1f, 4'h0, 7'h1f);
        add(5'h03, 5'b01111, 5'h1f, 4'hf, 7'h40);
        add(5'h04, 5'b11011, 5'h1f, 4'hf, 7'h00);
        add(5'h05, 5'b01111, 5'h1f, 4'hf, 7'h40);
        add(5'h05, 5'b01101, 5'h1f, 4'hf, 7'h00);
        add(5'h00, 5'b01111, 5'h1f, 4'h9, 7'h09);
        add(5'h10, 5'b01111, 5'h1f, 4'hf, 7'h60);
        add(5'h10, 5'b00110, 5'h1f, 4'hf, 7'h00);
        add(5'h11, 5'b01111, 5'h1f, 4'hf, 7'h40);
        add(5'h12, 5'b01111, 5'h1f, 4'hf, 7'h20);
        add(5'h13, 5'b11111, 5'h1f, 4'hf, 7'h00);
        add(5'h02, 5'b01111, 5'h1f, 4'hf, 7'h00);
        foreach (rows[i]) begin
            {delay_slot_flag_in, exc_store_in, exc_lmb_err_in,
             div_fault_kind_in, zone_fault_flag_in} = rows[i].fl;
            exc_cause_in = rows[i].c;
            exc_reg_in = rows[i].rg;
            exc_link_in = rows[i].lk;
            stream_data_in = 32'h5a00_0000 | 32'(i);
            pulse(exc_valid_in);
            e = {19'h0, rows[i].fl[4], rows[i].det, rows[i].c};
            rc("cause", `SEL_CAUSE, e);
            if (rows[i].c == `EC_STREAM)
                rc("sdata", `SEL_STREAM, 32'h5a00_0000 | 32'(i));
        end
        // flags only gather until a move replaces them
        fp_flags_in = 5'h11;
        pulse(fp_set_in);
        fp_flags_in = 5'h02;
        pulse(fp_set_in);
        rc("fsticky", `SEL_FLOAT, 32'h13);
        u_emsr_core_model.mts(`SEL_FLOAT, 32'h0);
        rc("fclear", `SEL_FLOAT, 32'h0);
        u_emsr_core_model.mts(`SEL_FLOAT, 32'hffff_ffff);
        rc("fwrite", `SEL_FLOAT, 32'h1f);
        // two branches with an idle cycle between, the second inside a handler
        branch_target_in = 32'h0000_4444;
        pulse(dslot_branch_in);
        handler_active_bit_in = 1'b1;
        branch_target_in = 32'h0000_8888;
        pulse(dslot_branch_in);
        handler_active_bit_in = 1'b0;
        u_emsr_core_model.mts(`SEL_BRANCH, 32'h0);
        rc("branch", `SEL_BRANCH, 32'h4444);
        // limits and the boundaries around them
        u_emsr_core_model.mts(`SEL_FLOOR, 32'h1000);
        u_emsr_core_model.mts(`SEL_CEIL, 32'h2000);
        ls(32'h0fff, 1'b1, 1'b1, 3'b101);
        ls(32'h2001, 1'b1, 1'b0, 3'b010);
        ls(32'h2000, 1'b1, 1'b1, 3'b000);
        ls(32'h1000, 1'b1, 1'b1, 3'b000);
        ls(32'h0000, 1'b0, 1'b1, 3'b000);
        // zones 0..3 = 01 00 11 10; page bits under the page size zero
        u_emsr_core_model.mts(`SEL_ZONE, 32'h4e00_0000);
        rc("zone", `SEL_ZONE, 32'h4e00_0000);
        lo_tab = '{32'h0, 32'h1234_5010, 32'h1234_5020, 32'h1234_5230,
                   32'hab00_0300};
        for (int i = 1; i < 5; i++) begin
            xlate_index_reg_in = 6'(i);
            u_emsr_core_model.mts(`SEL_XLO, lo_tab[i]);
        end
        rc("xlo", `SEL_XLO, lo_tab[4]);
        lku(1'b1, 6'd1, 3'd0, 4'b0000);
        lku(1'b1, 6'd2, 3'd0, 4'b1110);
        lku(1'b1, 6'd3, 3'd0, 4'b1010);
        lku(1'b0, 6'd1, 3'd0, 4'b1001);
        lku(1'b0, 6'd3, 3'd0, 4'b1110);
        lku(1'b1, 6'd4, 3'd1, 4'b1110);
        lk_entry_valid_in = 1'b0;
        lku(1'b0, 6'd3, 3'd0, 4'b0000);
        // tag goes out on high write, back only in privileged mode
        u_emsr_core_model.mts(`SEL_PTAG, 32'hffff_ffa5);
        rc("ptag", `SEL_PTAG, 32'ha5);
        xlate_index_reg_in = 6'd3;
        pulse(xhi_wr_in);
        @(negedge clk_in);
        `CHK("otag", 8'ha5, entry_owner_tag_out);
        u_emsr_core_model.mts(`SEL_PTAG, 32'h11);
        user_mode_bit_in = 1'b1;
        pulse(xhi_rd_in);
        rc("ptag", `SEL_PTAG, 32'h11);
        user_mode_bit_in = 1'b0;
        pulse(xhi_rd_in);
        rc("ptag", `SEL_PTAG, 32'ha5);
        // reset mid-run spares the table, configuration load clears it
        arst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        arst_n_in = 1'b1;
        rst_vals();
        rc("xlo kept", `SEL_XLO, lo_tab[3]);
        pulse(config_load_in);
        rc("xlo load", `SEL_XLO, 32'h0);
        end_of_test();
    end
endmodule // emsr_special_regs_tb_top
bind emsr_special_regs emsr_special_regs_chk u_emsr_special_regs_chk (
    .clk_in, .arst_n_in, .special_reg_selector_in, .rd_en_in, .wr_en_in,
    .wdata_in, .rdata_out, .exc_enable_in, .ls_valid_in, .ls_base_r1_in,
    .ls_addr_in, .stack_overflow_out, .stack_underflow_out,
    .stack_fault_out, .lk_req_in, .lk_ack_out, .lk_fetch_ok_out,
    .lk_fetch_fault_out);
`default_nettype wire
